/* pdr_powerdown_reset_control.sv */
/*
 * Power-down entry and exit, external-pin, watchdog and power-fail reset
 * sequencing, reset-cause flags and register reset values for an 8-bit core.
 * Assumes the core and interrupt controller run on ref_clk_i, that pins and
 * the oscillator-stable flag are asynchronous, and that the register port is
 * a plain strobe port with read data one cycle after the read strobe.
 */
// Local design decisions: the address map and the strobed register port.
// Function
// - Writing power-down bit halts after that instruction
// - Power-down stops clocks, strobes low, ports hold
// - Port zero floats externally; idle strobes high
// - Reset pin high ends power-down, restarts at zero
// - Watchdog cannot wake from power-down
// - Qualified low level interrupt pin wakes device
// - After wake service, continue after halting instruction
// - RC wake select runs RC then crystal
// - Reset pin sampled at fourth state each cycle
// - Pin reset applied synchronously with running clock
// - Reset held while pin high, plus two cycles
// - External reset sets no cause flag
// - Supply recovery repeats power-on delay, sets flag
// - Watchdog free runs, clears, flags at time-out
// - Uncleared enabled watchdog resets 512 clocks later
// - Watchdog reset held exactly two machine cycles
// - Reset forces program counter zero, stack 07h
// - Reset loads special register default patterns
// - Cause register reset pattern depends on source
// - Power-on, power-fail, watchdog flags set correctly
// - Watchdog reset enable cleared only by power-on; power-fail also clears it here
// - Machine cycle is four clocks
// - Any reset forces clock divide by four
`timescale 1ns/1ps
`default_nettype none

module pdr_powerdown_reset_control #(
	parameter int unsigned WD_BASE_CLK   = 131072,
	parameter int unsigned POR_DELAY_CLK = 65536
) (
	input  wire logic                         ref_clk_i,
	input  wire logic                         reset_i,
	input  wire logic [pdr_pkg::ADDR_W-1:0]   reg_addr_i,
	input  wire logic [pdr_pkg::DATA_W-1:0]   reg_wdata_i,
	input  wire logic                         reg_wr_i,
	input  wire logic                         reg_rd_i,
	output logic      [pdr_pkg::DATA_W-1:0]   reg_rdata_o,
	input  wire logic                         rst_pin_i,
	input  wire logic                         power_fail_i,
	input  wire logic [1:0]                   ext_int_n_i,
	input  wire logic [1:0]                   int_level_mode_i,
	input  wire logic [1:0]                   int_enable_i,
	input  wire logic                         global_interrupt_enable_i,
	input  wire logic                         idle_wake_i,
	input  wire logic                         osc_stable_i,
	input  wire logic                         ext_prog_mem_i,
	input  wire logic                         core_addr_latch_i,
	input  wire logic                         core_program_fetch_strobe_i,
	output logic                              core_reset_o,
	output logic                              core_clk_en_o,
	output logic                              osc_enable_o,
	output logic                              rc_select_o,
	output logic                              clk_div4_force_o,
	output logic                              addr_latch_o,
	output logic                              program_fetch_strobe_o,
	output logic                              port_hold_o,
	output logic                              port0_float_o,
	output logic                              port2_addr_o,
	output logic                              wake_irq_o,
	output logic [1:0]                        wake_src_o,
	output logic [15:0]                       pc_load_o,
	output logic [7:0]                        sp_load_o,
	output logic [7:0]                        port_init_o,
	output logic [7:0]                        timed_access_init_o,
	output logic [7:0]                        clock_control_init_o
);
	import pdr_pkg::*;

	// ------------------------------------------------------------------
	// Derived constants
	// ------------------------------------------------------------------
	localparam logic [23:0] POR_DELAY_LOAD = 24'(POR_DELAY_CLK - 1);
	localparam logic [31:0] WD_BASE = 32'(WD_BASE_CLK);

	pdr_regs_t r;
	pdr_regs_t n;

	logic [31:0] wd_limit;
	logic [1:0]  wake_vec;
	logic        wr_pc;
	logic        wr_ex;
	logic        wr_wd;
	logic        wr_sel;
	logic        wd_clear;
	logic        wd_timeout;
	logic        wd_fire;
	logic        pin_seen;

	// ------------------------------------------------------------------
	// Watchdog interval and wake qualification
	// ------------------------------------------------------------------
	always_comb begin
		case (r.wd_sel)
			2'h0: wd_limit = WD_BASE - 32'h00000001;
			2'h1: wd_limit = (WD_BASE << 3) - 32'h00000001;
			2'h2: wd_limit = (WD_BASE << 6) - 32'h00000001;
			default: wd_limit = (WD_BASE << 9) - 32'h00000001;
		endcase
	end

	// Only level-detect pins may wake; an edge needs the stopped clock to be seen.
	assign wake_vec = ~r.int_s2 & int_level_mode_i & int_enable_i
		& {2{global_interrupt_enable_i}};

	assign wr_pc = reg_wr_i && (reg_addr_i == REG_POWER_CONTROL);
	assign wr_ex = reg_wr_i && (reg_addr_i == REG_EXT_INT_FLAGS);
	assign wr_wd = reg_wr_i && (reg_addr_i == REG_WD_RESET_CAUSE);
	assign wr_sel = reg_wr_i && (reg_addr_i == REG_WD_INTERVAL);
	assign wd_clear = wr_wd && reg_wdata_i[WD_CLEAR_BIT];
	// The watchdog only counts while the core clock runs, so it never wakes power-down.
	assign wd_timeout = (r.state == ST_RUN) && (r.wd_cnt == wd_limit);
	assign wd_fire = (r.state == ST_RUN) && r.wd_pend && !wd_clear
		&& (r.wd_pend_cnt == WD_RESET_DELAY_CLK) && r.wdc[WD_RST_EN_BIT];
	assign pin_seen = (r.phase == PHASE_FOURTH) && r.rst_s2;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		n = r;
		n.wake_pulse = 1'b0;
		n.rdata = 8'h00;

		n.rst_s1 = rst_pin_i;
		n.rst_s2 = r.rst_s1;
		n.pf_s1 = power_fail_i;
		n.pf_s2 = r.pf_s1;
		n.int_s1 = ext_int_n_i;
		n.int_s2 = r.int_s1;
		n.stb_s1 = osc_stable_i;
		n.stb_s2 = r.stb_s1;

		// Machine-cycle phase is held at zero while the clock is stopped in power-down.
		if (r.state == ST_PDOWN) begin
			n.phase = 2'h0;
		end else begin
			n.phase = 2'(r.phase + 2'h1);
		end

		// Software writes first, so hardware sets below win over clears.
		if (wr_ex) begin
			n.rc_wake = reg_wdata_i[EX_RC_WAKE_BIT];
		end
		if (wr_sel) begin
			n.wd_sel = reg_wdata_i[1:0];
		end
		if (wr_wd) begin
			n.wdc[WD_RST_EN_BIT] = reg_wdata_i[WD_RST_EN_BIT];
			n.wdc[WD_RST_FLAG_BIT] = reg_wdata_i[WD_RST_FLAG_BIT];
			n.wdc[WD_INT_FLAG_BIT] = reg_wdata_i[WD_INT_FLAG_BIT];
			n.wdc[WD_PFAIL_BIT] = reg_wdata_i[WD_PFAIL_BIT];
			n.wdc[WD_POR_BIT] = reg_wdata_i[WD_POR_BIT];
		end
		if (wr_pc) begin
			n.idle = reg_wdata_i[PC_IDLE_BIT];
		end

		// Watchdog counter and pending reset.
		if (wd_clear) begin
			n.wd_cnt = 32'h00000000;
			n.wd_pend = 1'b0;
			n.wd_pend_cnt = 10'h000;
		end else if (r.state == ST_RUN) begin
			n.wd_cnt = wd_timeout ? 32'h00000000 : r.wd_cnt + 32'h00000001;
			if (wd_timeout) begin
				n.wdc[WD_INT_FLAG_BIT] = 1'b1;
				if (!r.wd_pend) begin
					n.wd_pend = 1'b1;
					n.wd_pend_cnt = 10'h000;
				end
			end
			if (r.wd_pend && (r.wd_pend_cnt != WD_RESET_DELAY_CLK)) begin
				n.wd_pend_cnt = 10'(r.wd_pend_cnt + 10'h001);
			end
		end

		if (idle_wake_i) begin
			n.idle = 1'b0;
		end

		case (r.state)
			ST_RUN: begin
				if (r.on_rc && r.stb_s2) begin
					n.on_rc = 1'b0;
				end
				if (pin_seen) begin
					n.state = ST_RESET;
					n.hold_cnt = RESET_HOLD_CLK;
					n.wdc = r.wdc & WDC_KEEP_EXT;
					n.idle = 1'b0;
				end else if (wd_fire) begin
					n.state = ST_RESET;
					n.hold_cnt = RESET_HOLD_CLK;
					n.wdc = (r.wdc & WDC_KEEP_WD) | (8'h01 << WD_RST_FLAG_BIT);
					n.idle = 1'b0;
				end else if (wr_pc && reg_wdata_i[PC_PD_BIT]) begin
					n.state = ST_PDOWN;
					n.idle = 1'b0;
				end
			end
			ST_PDOWN: begin
				if (r.rst_s2) begin
					n.state = ST_RESET;
					n.hold_cnt = RESET_HOLD_CLK;
					n.wdc = r.wdc & WDC_KEEP_EXT;
				end else if (|wake_vec) begin
					n.state = ST_WAKE;
					n.on_rc = r.rc_wake;
					n.wake_src = wake_vec[0] ? 2'h0 : 2'h1;
				end
			end
			ST_WAKE: begin
				if (r.rst_s2) begin
					n.state = ST_RESET;
					n.hold_cnt = RESET_HOLD_CLK;
					n.wdc = r.wdc & WDC_KEEP_EXT;
					n.on_rc = 1'b0;
				end else if (r.on_rc || r.stb_s2) begin
					// The core resumes without reset and so continues after the halt.
					n.state = ST_RUN;
					n.wake_pulse = 1'b1;
				end
			end
			ST_RESET: begin
				if (r.rst_s2) begin
					n.hold_cnt = RESET_HOLD_CLK;
				end else if (r.hold_cnt == 4'h0) begin
					n.state = ST_RUN;
				end else begin
					n.hold_cnt = 4'(r.hold_cnt - 4'h1);
				end
				n.wd_cnt = 32'h00000000;
				n.wd_pend = 1'b0;
				n.wd_pend_cnt = 10'h000;
				n.on_rc = 1'b0;
			end
			ST_PWRUP: begin
				if (r.pf_s2) begin
					n.por_cnt = POR_DELAY_LOAD;
				end else if (r.por_cnt == 24'h000000) begin
					n.state = ST_RESET;
					n.hold_cnt = RESET_HOLD_CLK;
					n.wdc[WD_POR_BIT] = 1'b1;
				end else begin
					n.por_cnt = 24'(r.por_cnt - 24'h000001);
				end
				n.wd_cnt = 32'h00000000;
				n.wd_pend = 1'b0;
				n.idle = 1'b0;
				n.on_rc = 1'b0;
			end
			default: begin
				n.state = ST_PWRUP;
			end
		endcase

		// A supply failure overrides every state and restarts the power-up delay.
		if (r.pf_s2 && (r.state != ST_PWRUP)) begin
			n.state = ST_PWRUP;
			n.por_cnt = POR_DELAY_LOAD;
			n.wdc = r.wdc & ~(8'h01 << WD_RST_EN_BIT);
			n.wdc[WD_PFAIL_BIT] = 1'b1;
		end

		// Register read data, registered for the following cycle.
		if (reg_rd_i) begin
			if (reg_addr_i == REG_POWER_CONTROL) begin
				n.rdata[PC_IDLE_BIT] = r.idle;
				n.rdata[PC_PD_BIT] = (r.state == ST_PDOWN);
			end else if (reg_addr_i == REG_EXT_INT_FLAGS) begin
				n.rdata[EX_RC_WAKE_BIT] = r.rc_wake;
				n.rdata[EX_ON_RC_BIT] = r.on_rc;
			end else if (reg_addr_i == REG_WD_RESET_CAUSE) begin
				n.rdata = r.wdc & ~(8'h01 << WD_CLEAR_BIT);
			end else if (reg_addr_i == REG_WD_INTERVAL) begin
				n.rdata = {6'h00, r.wd_sel};
			end else if (reg_addr_i == REG_STATUS) begin
				n.rdata = {1'b0, r.wd_pend, 1'b0, r.state};
			end else begin
				n.rdata = 8'h00;
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Power-on reset: cause register takes the power-on pattern.
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			r <= PDR_RESET_REGS;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign reg_rdata_o = r.rdata;
	assign core_reset_o = (r.state == ST_RESET) || (r.state == ST_PWRUP);
	assign core_clk_en_o = (r.state == ST_RUN) || (r.state == ST_RESET)
		|| (r.state == ST_PWRUP);
	assign osc_enable_o = (r.state != ST_PDOWN);
	assign rc_select_o = r.on_rc;
	assign clk_div4_force_o = core_reset_o;

	// Strobes: forced low in power-down, high in idle, else from the core.
	always_comb begin
		if (r.state == ST_PDOWN) begin
			addr_latch_o = 1'b0;
			program_fetch_strobe_o = 1'b0;
		end else if (r.idle) begin
			addr_latch_o = 1'b1;
			program_fetch_strobe_o = 1'b1;
		end else begin
			addr_latch_o = core_addr_latch_i;
			program_fetch_strobe_o = core_program_fetch_strobe_i;
		end
	end

	assign port_hold_o = (r.state == ST_PDOWN) || r.idle;
	assign port0_float_o = port_hold_o && ext_prog_mem_i;
	assign port2_addr_o = r.idle && (r.state != ST_PDOWN) && ext_prog_mem_i;
	assign wake_irq_o = r.wake_pulse;
	assign wake_src_o = r.wake_src;

	// Reset loads; the core applies them while core_reset_o is high.
	assign pc_load_o = PC_RESET_VALUE;
	assign sp_load_o = SP_RESET_VALUE;
	assign port_init_o = PORT_RESET_VALUE;
	assign timed_access_init_o = TA_RESET_VALUE;
	assign clock_control_init_o = CLOCK_CONTROL_REG_RESET_VALUE;

endmodule // pdr_powerdown_reset_control

`default_nettype wire

/* pdr_pkg.sv */
/*
 * Package for the power-down and reset control block: register indices,
 * field positions, reset patterns, cycle counts, the state enumeration and
 * the packed state record of the control module.
 * Assumes a single 40 MHz system clock and an 8-bit register port.
 */
`default_nettype none

package pdr_pkg;

	// ------------------------------------------------------------------
	// Bus widths and register indices
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] REG_POWER_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_EXT_INT_FLAGS = 8'h01;
	localparam logic [ADDR_W-1:0] REG_WD_RESET_CAUSE = 8'h02;
	localparam logic [ADDR_W-1:0] REG_WD_INTERVAL = 8'h03;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int PC_IDLE_BIT = 0;
	localparam int PC_PD_BIT = 1;
	localparam int EX_RC_WAKE_BIT = 1;
	localparam int EX_ON_RC_BIT = 2;
	localparam int WD_CLEAR_BIT = 0;
	localparam int WD_RST_EN_BIT = 1;
	localparam int WD_RST_FLAG_BIT = 2;
	localparam int WD_INT_FLAG_BIT = 3;
	localparam int WD_PFAIL_BIT = 4;
	localparam int WD_POR_BIT = 6;

	// ------------------------------------------------------------------
	// Reset patterns
	// ------------------------------------------------------------------
	localparam logic [7:0] WDC_POR_VALUE = 8'h40;
	localparam logic [7:0] WDC_KEEP_EXT = 8'h56;
	localparam logic [7:0] WDC_KEEP_WD = 8'h52;
	localparam logic [15:0] PC_RESET_VALUE = 16'h0000;
	localparam logic [7:0] SP_RESET_VALUE = 8'h07;
	localparam logic [7:0] PORT_RESET_VALUE = 8'hFF;
	localparam logic [7:0] TA_RESET_VALUE = 8'hFF;
	localparam logic [7:0] CLOCK_CONTROL_REG_RESET_VALUE = 8'h01;

	// ------------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------------
	localparam int CLK_PER_MC = 4;
	localparam logic [1:0] PHASE_FOURTH = 2'h3;
	localparam int RESET_HOLD_MC = 2;
	localparam logic [3:0] RESET_HOLD_CLK = 4'(RESET_HOLD_MC * CLK_PER_MC - 1);
	localparam logic [9:0] WD_RESET_DELAY_CLK = 10'h1FF;

	// ------------------------------------------------------------------
	// States and state record
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_RUN   = 5'b00001,
		ST_PDOWN = 5'b00010,
		ST_WAKE  = 5'b00100,
		ST_RESET = 5'b01000,
		ST_PWRUP = 5'b10000
	} pdr_state_t;

	typedef struct packed {
		pdr_state_t  state;
		logic [1:0]  phase;
		logic        rst_s1;
		logic        rst_s2;
		logic        pf_s1;
		logic        pf_s2;
		logic [1:0]  int_s1;
		logic [1:0]  int_s2;
		logic        stb_s1;
		logic        stb_s2;
		logic [3:0]  hold_cnt;
		logic [23:0] por_cnt;
		logic [31:0] wd_cnt;
		logic        wd_pend;
		logic [9:0]  wd_pend_cnt;
		logic [1:0]  wd_sel;
		logic        idle;
		logic        rc_wake;
		logic        on_rc;
		logic [7:0]  wdc;
		logic [7:0]  rdata;
		logic        wake_pulse;
		logic [1:0]  wake_src;
	} pdr_regs_t;

	localparam pdr_regs_t PDR_RESET_REGS = '{
		state: ST_PWRUP, phase: 2'h0, rst_s1: 1'b0, rst_s2: 1'b0,
		pf_s1: 1'b0, pf_s2: 1'b0, int_s1: 2'h3, int_s2: 2'h3,
		stb_s1: 1'b0, stb_s2: 1'b0, hold_cnt: 4'h0, por_cnt: 24'h000000,
		wd_cnt: 32'h00000000, wd_pend: 1'b0, wd_pend_cnt: 10'h000,
		wd_sel: 2'h0, idle: 1'b0, rc_wake: 1'b0, on_rc: 1'b0,
		wdc: WDC_POR_VALUE, rdata: 8'h00, wake_pulse: 1'b0, wake_src: 2'h0
	};

endpackage

`default_nettype wire

/* pdr_far_model.sv */
/*
 * Far-side model: crystal start-up, core strobes and a reset pin driver.
 * Assumes the bench clock and the block's oscillator and clock enables.
 */
`timescale 1ns/1ps
`default_nettype none

module pdr_far_model #(
	parameter int XTAL_START = 20
) (
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic osc_enable_i,
	input  wire logic core_clk_en_i,
	input  wire logic rst_req_i,
	output logic      osc_stable_o,
	output logic      ale_o,
	output logic      fetch_o,
	output logic      rst_pin_o
);
	// ----------
	// Crystal, core and pin
	// ----------
	int xtal_cnt;
	int pin_cnt;

	// The crystal restarts from cold each time, so a wake never sees it stable at once.
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !osc_enable_i)
			xtal_cnt <= 0;
		else if (xtal_cnt < XTAL_START)
			xtal_cnt <= xtal_cnt + 1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pin_cnt <= 0;
			ale_o <= 1'b1;
		end else begin
			pin_cnt <= rst_req_i ? 8 : (pin_cnt > 0 ? pin_cnt - 1 : 0);
			ale_o <= core_clk_en_i ? !ale_o : 1'b1;
		end
	end

	assign osc_stable_o = osc_enable_i && xtal_cnt == XTAL_START;
	assign fetch_o = !ale_o || !core_clk_en_i;
	assign rst_pin_o = rst_req_i || pin_cnt > 0;
endmodule // pdr_far_model

`default_nettype wire

/* pdr_powerdown_reset_control_chk.sv */
/*
 * Checker for the power-down and reset control block, bound to its ports.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pdr_powerdown_reset_control_chk (
	input wire logic                       ref_clk_i,
	input wire logic                       reset_i,
	input wire logic [pdr_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [pdr_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic                       reg_wr_i,
	input wire logic                       rst_pin_i,
	input wire logic                       power_fail_i,
	input wire logic [1:0]                 ext_int_n_i,
	input wire logic [1:0]                 int_level_mode_i,
	input wire logic [1:0]                 int_enable_i,
	input wire logic                       global_interrupt_enable_i,
	input wire logic                       osc_stable_i,
	input wire logic                       core_reset_o,
	input wire logic                       core_clk_en_o,
	input wire logic                       osc_enable_o,
	input wire logic                       rc_select_o,
	input wire logic                       clk_div4_force_o,
	input wire logic                       addr_latch_o,
	input wire logic                       program_fetch_strobe_o,
	input wire logic                       port_hold_o,
	input wire logic                       wake_irq_o
);
	import pdr_pkg::*;
	// ----------
	// Properties
	// ----------
	logic wake_req;
	logic quiet;

	assign wake_req = |(~ext_int_n_i & int_level_mode_i & int_enable_i) && global_interrupt_enable_i;
	assign quiet = !rst_pin_i && !power_fail_i && !wake_req;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	AST_PD_ENTRY: assert property (
		reg_wr_i && reg_addr_i == REG_POWER_CONTROL && reg_wdata_i[PC_PD_BIT] && core_clk_en_o
		&& !core_reset_o && !rst_pin_i && !power_fail_i |=> !osc_enable_o)
		else $error("power-down write did not halt");
	AST_PD_PINS: assert property (
		!osc_enable_o |-> !addr_latch_o && !program_fetch_strobe_o && port_hold_o
		&& !core_clk_en_o) else $error("power-down pin state wrong");
	AST_PD_STAYS: assert property (
		(!osc_enable_o && quiet) [*3] |=> !osc_enable_o) else $error("left power-down unasked");
	AST_PIN_RESET: assert property (
		rst_pin_i [*8] |=> core_reset_o) else $error("reset pin not taken");
	AST_PIN_HOLD: assert property (
		$fell(rst_pin_i) && core_reset_o && !power_fail_i
		|-> core_reset_o [*8] ##[1:6] !core_reset_o) else $error("reset release timing wrong");
	AST_INT_WAKE: assert property (
		!osc_enable_o && wake_req |-> ##[1:4] osc_enable_o) else $error("no interrupt wake");
	AST_DIV4: assert property (
		clk_div4_force_o == core_reset_o) else $error("divider force differs from reset");
	AST_RESUME: assert property (
		$rose(wake_irq_o) |-> !core_reset_o && core_clk_en_o ##1 !wake_irq_o)
		else $error("wake resume wrong");
	AST_XTAL_WAIT: assert property (
		$rose(core_clk_en_o) && !core_reset_o && !rc_select_o |-> $past(osc_stable_i, 2))
		else $error("core ran before crystal stable");

	COV_PD: cover property (!osc_enable_o);
	COV_WAKE: cover property (wake_irq_o);
	COV_RST: cover property ($rose(core_reset_o));
endmodule // pdr_powerdown_reset_control_chk

bind pdr_powerdown_reset_control pdr_powerdown_reset_control_chk u_chk (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .rst_pin_i(rst_pin_i),
	.power_fail_i(power_fail_i), .ext_int_n_i(ext_int_n_i), .int_level_mode_i(int_level_mode_i),
	.int_enable_i(int_enable_i), .global_interrupt_enable_i(global_interrupt_enable_i),
	.osc_stable_i(osc_stable_i), .core_reset_o(core_reset_o), .core_clk_en_o(core_clk_en_o),
	.osc_enable_o(osc_enable_o), .rc_select_o(rc_select_o), .clk_div4_force_o(clk_div4_force_o),
	.addr_latch_o(addr_latch_o), .program_fetch_strobe_o(program_fetch_strobe_o),
	.port_hold_o(port_hold_o), .wake_irq_o(wake_irq_o));

`default_nettype wire

/* pdr_powerdown_reset_control_tb.sv */
/*
 * Bench for the power-down and reset control block.
 * Assumes the far-side model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module pdr_powerdown_reset_control_tb;
	import pdr_pkg::*;
	// ----------
	// Signals and instances
	// ----------
	logic        ref_clk_i, reset_i, wr, rd, pfail, gie, iwake, xmem, rreq;
	logic        crst, clken, osc, rcsel, div4, ale_o, fet_o, hold, p0f, p2a, wirq;
	logic        stab, ale, fet, pin;
	logic [7:0]  addr, wdata, rdata, spl, pinit, tinit, cinit;
	logic [1:0]  int_n, lvl, ien, wsrc;
	logic [15:0] pcl;
	int          n_fail, check_count;

	// Short counts keep the run small; expectations below use these same values.
	pdr_powerdown_reset_control #(.WD_BASE_CLK(64), .POR_DELAY_CLK(16)) DUT (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rst_pin_i(pin),
		.power_fail_i(pfail), .ext_int_n_i(int_n), .int_level_mode_i(lvl), .int_enable_i(ien),
		.global_interrupt_enable_i(gie), .idle_wake_i(iwake), .osc_stable_i(stab),
		.ext_prog_mem_i(xmem), .core_addr_latch_i(ale), .core_program_fetch_strobe_i(fet),
		.core_reset_o(crst), .core_clk_en_o(clken), .osc_enable_o(osc), .rc_select_o(rcsel),
		.clk_div4_force_o(div4), .addr_latch_o(ale_o), .program_fetch_strobe_o(fet_o),
		.port_hold_o(hold), .port0_float_o(p0f), .port2_addr_o(p2a), .wake_irq_o(wirq),
		.wake_src_o(wsrc), .pc_load_o(pcl), .sp_load_o(spl), .port_init_o(pinit),
		.timed_access_init_o(tinit), .clock_control_init_o(cinit));
	pdr_far_model FAR (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .osc_enable_i(osc),
		.core_clk_en_i(clken), .rst_req_i(rreq), .osc_stable_o(stab), .ale_o(ale),
		.fetch_o(fet), .rst_pin_o(pin));

	// ----------
	// Helpers
	// ----------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick;
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic cyc(input int n);
		repeat (n) tick;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask
	task automatic wait_for(ref logic s, input logic v, input int lim, input string nm);
		int i;
		for (i = 0; i < lim && s !== v; i++)
			tick;
		chk(nm, v, s);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------
	// Scenarios
	// ----------
	task automatic t_por;
		chk("pc load", 16'h0000, pcl);
		chk("sp load", 8'h07, spl);
		chk("port ta inits", 16'hFFFF, {pinit, tinit});
		chk("clock_control_reg init", 16'h0001, {8'h00, cinit});
		wait_for(crst, 1'b0, 200, "por end");
		rd_chk(REG_WD_RESET_CAUSE, 8'h40, "por cause");
		wr_reg(REG_WD_RESET_CAUSE, 8'h00);
		rd_chk(REG_WD_RESET_CAUSE, 8'h00, "cause cleared");
		rd_chk(8'h7F, 8'h00, "unmapped");
		chk("run strobes", {14'h0000, ale, fet}, {14'h0000, ale_o, fet_o});
	endtask
	task automatic t_idle;
		xmem <= 1'b1;
		wr_reg(REG_POWER_CONTROL, 8'h01);
		cyc(2);
		chk("idle pins", 5'h1F, {ale_o, fet_o, hold, p0f, p2a});
		iwake <= 1'b1;
		cyc(3);
		iwake <= 1'b0;
		chk("idle end", 1'b0, hold);
		xmem <= 1'b0;
	endtask
	task automatic t_pd_int;
		int p;
		for (p = 0; p < 2; p++) begin
			lvl <= p ? 2'b10 : 2'b01;
			ien <= p ? 2'b10 : 2'b01;
			wr_reg(REG_POWER_CONTROL, 8'h02);
			cyc(2);
			chk("pd osc", 1'b0, osc);
			chk("pd pins", 4'b0010, {ale_o, fet_o, hold, p0f});
			int_n <= p ? 2'b01 : 2'b10;
			cyc(12);
			if (p == 0) begin
				chk("no enable wake", 1'b0, osc);
				gie <= 1'b1;
			end
			wait_for(osc, 1'b1, 10, "wake osc");
			chk("wake halt", 1'b0, clken);
			wait_for(wirq, 1'b1, 60, "wake irq");
			chk("wake src", 2'(p), wsrc);
			chk("no reset", 1'b0, crst);
			int_n <= 2'b11;
		end
	endtask
	task automatic t_rc;
		wr_reg(REG_EXT_INT_FLAGS, 8'h02);
		lvl <= 2'b01;
		ien <= 2'b01;
		wr_reg(REG_POWER_CONTROL, 8'h02);
		cyc(2);
		int_n <= 2'b10;
		wait_for(wirq, 1'b1, 10, "rc wake");
		chk("on rc", 1'b1, rcsel);
		int_n <= 2'b11;
		rd_chk(REG_EXT_INT_FLAGS, 8'h06, "rc flags");
		wait_for(rcsel, 1'b0, 60, "to crystal");
		wr_reg(REG_EXT_INT_FLAGS, 8'h00);
	endtask
	task automatic t_pd_pin;
		wr_reg(REG_WD_RESET_CAUSE, 8'h03);
		wr_reg(REG_POWER_CONTROL, 8'h02);
		cyc(700);
		chk("wd no wake", 1'b0, osc);
		rreq <= 1'b1;
		tick;
		rreq <= 1'b0;
		wait_for(crst, 1'b1, 20, "pin reset");
		chk("clock back", 1'b1, osc);
		wait_for(crst, 1'b0, 40, "pin end");
		rd_chk(REG_WD_RESET_CAUSE, 8'h02, "ext cause");
	endtask
	task automatic t_wd;
		int i;
		int n;
		for (i = 0; i < 10; i++) begin
			wr_reg(REG_WD_RESET_CAUSE, 8'h03);
			cyc(40);
			chk("cleared no reset", 1'b0, crst);
		end
		wr_reg(REG_WD_RESET_CAUSE, 8'h03);
		cyc(70);
		rd_chk(REG_WD_RESET_CAUSE, 8'h0A, "wd flag");
		for (n = 0; n < 800 && crst !== 1'b1; n++)
			tick;
		chk("wd span", 1'b1, n >= 500 && n <= 515);
		for (n = 0; n < 20 && crst === 1'b1; n++)
			tick;
		chk("wd hold", 16'h0008, 16'(n));
		rd_chk(REG_WD_RESET_CAUSE, 8'h06, "wd cause");
		rd_chk(REG_STATUS, 8'h01, "status run");
		wr_reg(REG_WD_INTERVAL, 8'h01);
		rd_chk(REG_WD_INTERVAL, 8'h01, "interval");
		wr_reg(REG_WD_RESET_CAUSE, 8'h03);
		cyc(300);
		rd_chk(REG_WD_RESET_CAUSE, 8'h02, "long interval");
	endtask
	task automatic t_pfail;
		wr_reg(REG_WD_RESET_CAUSE, 8'h02);
		pfail <= 1'b1;
		cyc(10);
		chk("pfail reset", 1'b1, crst);
		chk("div4 force", 1'b1, div4);
		pfail <= 1'b0;
		wait_for(crst, 1'b0, 100, "pfail end");
		rd_chk(REG_WD_RESET_CAUSE, 8'h50, "pfail cause");
	endtask

	// ----------
	// Sequence
	// ----------
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		reset_i = 1'b1;
		{wr, rd, pfail, gie, iwake, xmem, rreq} = '0;
		{addr, wdata} = '0;
		{lvl, ien} = '0;
		int_n = 2'b11;
		cyc(20);
		reset_i <= 1'b0;
		t_por;
		t_idle;
		t_pd_int;
		t_rc;
		t_pd_pin;
		t_wd;
		t_pfail;
		stop_test;
	end
	// Far beyond the few thousand cycles the sequence needs.
	initial begin
		cyc(20000);
		n_fail++;
		stop_test;
	end
endmodule // pdr_powerdown_reset_control_tb

`default_nettype wire
